/* verilog/eeprom_pkg.sv */
// Shared constants for the protect and hold logic of the serial EEPROM.
`default_nettype none
package eeprom_pkg;
   // Array geometry; the two top address bits of a command are dropped.
   localparam int ADDR_W = 14;
   localparam int DATA_W = 8;
   localparam int FRAME_W = 32;
   localparam int CNT_W = 6;
   // Status byte layout.
   localparam int ST_LOCK = 7;
   localparam int ST_LVL_HI = 3;
   localparam int ST_LVL_LO = 2;
   localparam int ST_WEL = 1;
   localparam int ST_WIP = 0;
   // Protect-level codes and the first protected address of each.
   localparam logic [1:0] LVL_NONE = 2'h0;
   localparam logic [1:0] LVL_QUARTER = 2'h1;
   localparam logic [1:0] LVL_HALF = 2'h2;
   localparam logic [1:0] LVL_ALL = 2'h3;
   localparam logic [ADDR_W-1:0] QUARTER_BASE = 14'h3000;
   localparam logic [ADDR_W-1:0] HALF_BASE = 14'h2000;
   localparam logic [ADDR_W-1:0] ALL_BASE = 14'h0000;
   localparam logic [ADDR_W-1:0] ARRAY_TOP = 14'h3FFF;
   // Exact clock counts that make a frame valid.
   localparam logic [CNT_W-1:0] LEN_SHORT = 6'h08;
   localparam logic [CNT_W-1:0] LEN_STATUS = 6'h10;
   localparam logic [CNT_W-1:0] LEN_WRITE = 6'h20;
   localparam logic [CNT_W-1:0] LEN_NONE = 6'h00;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
   // Reset values of the status bits.
   localparam logic RST_LOCK = 1'h0;
   localparam logic [1:0] RST_LVL = 2'h0;
   localparam logic RST_WEL = 1'h0;
   // Busy time of a write, in mclk cycles.
   localparam int WRITE_BUSY_DEFAULT = 1000;
endpackage : eeprom_pkg
`default_nettype wire

/* verilog/sync_3ff.sv */
// Three-stage synchroniser that accepts a bit once stages two and three agree.
`default_nettype none
module sync_3ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Crossing data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_q;
   wire logic [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
   wire logic [WIDTH-1:0] out_d = (s3_q & agree) | (out_q & ~agree);

   generate
      if (WIDTH < 1) begin : g_bad
         $error("sync_3ff needs a width of at least one");
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         out_q <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign q = out_q;
endmodule : sync_3ff
`default_nettype wire

/* verilog/protect_decode.sv */
// Write permission decode from protect level, lock bit, protect pin and latch.
`default_nettype none
module protect_decode (
   // Status state
   input wire logic [1:0] protectLevel,
   input wire logic statusLock,
   input wire logic writeEnableLatch,
   input wire logic busy,
   // Protect pin, already synchronised
   input wire logic wpN,
   // Target of a memory write
   input wire logic [eeprom_pkg::ADDR_W-1:0] addr,
   // Verdicts
   output logic memWriteOk,
   output logic statusWriteOk,
   output logic hardwareLockMode,
   output logic softwareLockMode
);
   import eeprom_pkg::*;

   function automatic logic inRegion(input logic [1:0] lvl,
                                     input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      case (lvl)
         LVL_NONE: hit = 1'b0;
         LVL_QUARTER: hit = (a >= QUARTER_BASE) && (a <= ARRAY_TOP);
         LVL_HALF: hit = (a >= HALF_BASE) && (a <= ARRAY_TOP);
         LVL_ALL: hit = (a >= ALL_BASE) && (a <= ARRAY_TOP);
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction : inRegion

   wire logic addrLocked = inRegion(protectLevel, addr); // R6 R16
   wire logic hwLock = statusLock && !wpN; // R3 R4 R5

   assign hardwareLockMode = hwLock;
   assign softwareLockMode = !hwLock;
   assign memWriteOk = writeEnableLatch && !busy && !addrLocked; // R7 R16
   assign statusWriteOk = writeEnableLatch && !busy && !hwLock; // R1 R2 R3 R7
endmodule : protect_decode
`default_nettype wire

/* verilog/eeprom_protect_hold.sv */
// Protect, hold and supply-drop logic of the serial EEPROM front end.
//
// What this block does, and what it expects of the host
// R1: Lock bit clear lets a status write change status, if latch set.
// R2: Lock bit set with protect pin high still accepts status writes.
// R3: Lock bit set with protect pin low rejects status writes.
// R4: Hardware lock entered by lock bit then pin low, or either order.
// R5: Protect pin high releases hardware lock; protect levels still apply.
// R6: Protect levels guard none, 3000h-3FFFh, 2000h-3FFFh or the whole array.
// R7: Latch clear refuses all writes; protected range never writable.
// R8: In hold the output floats and data input and clock are ignored.
// R9: Host keeps select low throughout hold.
// R10: Raising select during hold deselects and kills the command.
// R11: Pause change with clock low starts or ends hold at once.
// R12: Pause change with clock high takes effect at next clock fall.
// R13: Supply drop or power-on cancels writes and clears the latch.
// R14: Host reissues write enable after a supply drop before writing.
// R15: No write ever happens while select is low.
// R16: Memory write into a protected address is ignored.
// R17: Status write changes only lock and level bits; bits 6..4 read zero.
// R18: The two top address bits are ignored; decode over 14 bits.
`default_nettype none
module eeprom_protect_hold #(
   parameter logic [7:0] OP_WRITE_ENABLE = 8'h11,
   parameter logic [7:0] OP_WRITE_DISABLE = 8'h12,
   parameter logic [7:0] OP_STATUS_READ = 8'h13,
   parameter logic [7:0] OP_STATUS_WRITE = 8'h14,
   parameter logic [7:0] OP_MEM_WRITE = 8'h15,
   parameter int WRITE_BUSY_CYCLES = eeprom_pkg::WRITE_BUSY_DEFAULT
) (
   // System clock and supply detector reset
   input wire logic mclk,
   input wire logic rst_n,
   // Serial link pins
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic wpN,
   input wire logic holdN,
   output logic so,
   output logic soOe,
   // Write port toward the array
   output logic memWrEn,
   output logic [eeprom_pkg::ADDR_W-1:0] memWrAddr,
   output logic [eeprom_pkg::DATA_W-1:0] memWrData,
   // Status bits
   output logic statusLock,
   output logic [1:0] protectLevel,
   output logic writeEnableLatch,
   output logic writeInProgress,
   output logic hardwareLockMode,
   output logic softwareLockMode
);
   import eeprom_pkg::*;

   localparam int BUSY_W = $clog2(WRITE_BUSY_CYCLES + 1);
   localparam logic [BUSY_W-1:0] BUSY_LAST =
      BUSY_W'(WRITE_BUSY_CYCLES - 1);
   localparam int SNAP_W = 1 + 8 + ADDR_W + DATA_W;

   generate
      if (WRITE_BUSY_CYCLES < 1) begin : g_bad_busy
         $error("write busy time must be at least one cycle");
      end
      if (OP_WRITE_ENABLE == OP_WRITE_DISABLE ||
          OP_WRITE_ENABLE == OP_STATUS_READ ||
          OP_WRITE_ENABLE == OP_STATUS_WRITE ||
          OP_WRITE_ENABLE == OP_MEM_WRITE ||
          OP_WRITE_DISABLE == OP_STATUS_READ ||
          OP_WRITE_DISABLE == OP_STATUS_WRITE ||
          OP_WRITE_DISABLE == OP_MEM_WRITE ||
          OP_STATUS_READ == OP_STATUS_WRITE ||
          OP_STATUS_READ == OP_MEM_WRITE ||
          OP_STATUS_WRITE == OP_MEM_WRITE) begin : g_bad_op
         $error("command codes must be distinct");
      end
   endgenerate

   // Frame length that makes a command valid; zero means never executed.
   function automatic logic [CNT_W-1:0] cmdLength(input logic [7:0] op);
      logic [CNT_W-1:0] len;
      len = LEN_NONE;
      if (op == OP_WRITE_ENABLE || op == OP_WRITE_DISABLE) begin
         len = LEN_SHORT;
      end else if (op == OP_STATUS_WRITE) begin
         len = LEN_STATUS;
      end else if (op == OP_MEM_WRITE) begin
         len = LEN_WRITE;
      end
      return len;
   endfunction : cmdLength

   // ---------------- Link side, clocked by sck ----------------

   logic [CNT_W-1:0] bitCnt_q;
   logic [FRAME_W-1:0] shift_q;
   logic [7:0] opcode_q;
   logic rdActive_q;
   logic heldAtFall_q;
   logic [7:0] outSh_q;
   logic [2:0] outCnt_q;
   logic outLive_q;
   logic snapValid_q;
   logic [7:0] snapOp_q;
   logic [ADDR_W-1:0] snapAddr_q;
   logic [DATA_W-1:0] snapData_q;
   logic [7:0] statusSck;

   // With the clock high the hold state is frozen at its last falling
   // edge; with the clock low it follows the pause pin directly.
   wire logic holdActive = sck ? heldAtFall_q : !holdN; // R11 R12
   wire logic [FRAME_W-1:0] shiftNext = {shift_q[FRAME_W-2:0], si};
   wire logic [CNT_W-1:0] cntNext =
      (bitCnt_q == CNT_MAX) ? CNT_MAX : bitCnt_q + 6'h01;
   wire logic [7:0] opNow = (cntNext == LEN_SHORT) ?
      shiftNext[7:0] : opcode_q;
   wire logic [CNT_W-1:0] lenNow = cmdLength(opNow);
   wire logic lenMatch = (lenNow != LEN_NONE) && (cntNext == lenNow);

   // Select high clears the frame at once, so a raised select ends any
   // command, held or not. Just before a rise the clock was low, so the
   // hold state then is the pause pin itself, not the last falling sample.
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin // R10 R15
         bitCnt_q <= '0;
         shift_q <= '0;
         opcode_q <= '0;
         rdActive_q <= 1'b0;
      end else if (holdN) begin // R8 R11
         bitCnt_q <= cntNext;
         shift_q <= shiftNext;
         if (cntNext == LEN_SHORT) begin
            opcode_q <= shiftNext[7:0];
            rdActive_q <= (shiftNext[7:0] == OP_STATUS_READ);
         end
      end
   end

   // The snapshot outlives select so the system side can judge the frame
   // after select rises; any clock past the exact length voids it.
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         snapValid_q <= 1'b0;
         snapOp_q <= '0;
         snapAddr_q <= '0;
         snapData_q <= '0;
      end else if (!csN && holdN) begin // R8 R11
         snapValid_q <= lenMatch;
         snapOp_q <= opNow;
         snapAddr_q <= shiftNext[ADDR_W+7:8]; // R18
         snapData_q <= shiftNext[7:0];
      end
   end

   // Falling edges sample the pause pin and shift the status byte out.
   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         heldAtFall_q <= 1'b0;
         outSh_q <= '0;
         outCnt_q <= '0;
         outLive_q <= 1'b0;
      end else begin
         heldAtFall_q <= !holdN; // R12
         if (holdN && rdActive_q) begin // R8
            outLive_q <= 1'b1;
            outCnt_q <= outCnt_q + 3'h1;
            if (outCnt_q == 3'h0) begin
               outSh_q <= statusSck;
            end else begin
               outSh_q <= {outSh_q[6:0], 1'b0};
            end
         end
      end
   end

   assign so = outSh_q[7];
   assign soOe = !csN && outLive_q && !holdActive; // R8

   // ---------------- System side, clocked by mclk ----------------

   logic [1:0] rstPipe_q;
   wire logic rstSync_n = rstPipe_q[1];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe_q <= 2'h0;
      end else begin
         rstPipe_q <= {rstPipe_q[0], 1'b1};
      end
   end

   logic csS;
   logic wpS;
   logic holdS;
   logic snapValidS;
   logic [7:0] snapOpS;
   logic [ADDR_W-1:0] snapAddrS;
   logic [DATA_W-1:0] snapDataS;

   sync_3ff #(.WIDTH(3), .INIT(3'h6)) u_pin_sync (
      .clk(mclk),
      .rst_n(rstSync_n),
      .d({csN, wpN, holdActive}),
      .q({csS, wpS, holdS})
   );

   sync_3ff #(.WIDTH(SNAP_W), .INIT('0)) u_frame_sync (
      .clk(mclk),
      .rst_n(rstSync_n),
      .d({snapValid_q, snapOp_q, snapAddr_q, snapData_q}),
      .q({snapValidS, snapOpS, snapAddrS, snapDataS})
   );

   logic csPrev_q;
   logic holdPrev_q;
   logic lock_q;
   logic [1:0] level_q;
   logic wel_q;
   logic busy_q;
   logic [BUSY_W-1:0] busyCnt_q;
   logic pendStatus_q;
   logic pendLock_q;
   logic [1:0] pendLevel_q;
   logic memWrEn_q;
   logic [ADDR_W-1:0] memWrAddr_q;
   logic [DATA_W-1:0] memWrData_q;
   logic hwLock_q;
   logic swLock_q;
   logic memOk;
   logic statusOk;
   logic hwLockNow;
   logic swLockNow;

   protect_decode u_protect (
      .protectLevel(level_q),
      .statusLock(lock_q),
      .writeEnableLatch(wel_q),
      .busy(busy_q),
      .wpN(wpS),
      .addr(snapAddrS),
      .memWriteOk(memOk),
      .statusWriteOk(statusOk),
      .hardwareLockMode(hwLockNow),
      .softwareLockMode(swLockNow)
   );

   // Frames act only on the rise of select, never while it stays high,
   // and never when select was raised out of a hold.
   wire logic csRise = csS && !csPrev_q;
   wire logic frameGo = csRise && snapValidS && !holdPrev_q; // R10 R15
   wire logic goEnable = frameGo && (snapOpS == OP_WRITE_ENABLE);
   wire logic goDisable = frameGo && (snapOpS == OP_WRITE_DISABLE);
   wire logic goStatus = frameGo && (snapOpS == OP_STATUS_WRITE)
      && statusOk; // R1 R2 R3 R7
   wire logic goMem = frameGo && (snapOpS == OP_MEM_WRITE)
      && memOk; // R7 R16
   wire logic busyDone = busy_q && (busyCnt_q == BUSY_LAST);

   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         csPrev_q <= 1'b1;
         holdPrev_q <= 1'b0;
      end else begin
         csPrev_q <= csS;
         holdPrev_q <= holdS;
      end
   end

   // Supply drop is the reset: it cancels a pending write and clears the
   // latch. Lock and level bits are flip-flops here, so they also return
   // to their delivery values; a real array would reload them.
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin // R13
         wel_q <= RST_WEL;
         busy_q <= 1'b0;
         busyCnt_q <= '0;
         pendStatus_q <= 1'b0;
      end else begin
         if (busyDone || goDisable) begin
            wel_q <= 1'b0;
         end else if (goEnable && !busy_q) begin
            wel_q <= 1'b1;
         end
         if (goStatus || goMem) begin
            busy_q <= 1'b1;
            busyCnt_q <= '0;
            pendStatus_q <= goStatus;
         end else if (busyDone) begin
            busy_q <= 1'b0;
            pendStatus_q <= 1'b0;
         end else if (busy_q) begin
            busyCnt_q <= busyCnt_q + BUSY_W'(1);
         end
      end
   end

   // New lock and level values only show once the write time is over.
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         lock_q <= RST_LOCK;
         level_q <= RST_LVL;
         pendLock_q <= RST_LOCK;
         pendLevel_q <= RST_LVL;
      end else begin
         if (goStatus) begin // R17
            pendLock_q <= snapDataS[ST_LOCK];
            pendLevel_q <= {snapDataS[ST_LVL_HI], snapDataS[ST_LVL_LO]};
         end
         if (busyDone && pendStatus_q) begin // R17
            lock_q <= pendLock_q;
            level_q <= pendLevel_q;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         memWrEn_q <= 1'b0;
         memWrAddr_q <= '0;
         memWrData_q <= '0;
         hwLock_q <= 1'b0;
         swLock_q <= 1'b1;
      end else begin
         memWrEn_q <= goMem; // R16
         if (goMem) begin
            memWrAddr_q <= snapAddrS; // R18
            memWrData_q <= snapDataS;
         end
         hwLock_q <= hwLockNow; // R4 R5
         swLock_q <= swLockNow;
      end
   end

   // Status byte as software reads it; bits 6 to 4 are always zero.
   logic [7:0] statusByte;
   always_comb begin
      statusByte = 8'h00; // R17
      statusByte[ST_LOCK] = lock_q;
      statusByte[ST_LVL_HI] = level_q[1];
      statusByte[ST_LVL_LO] = level_q[0];
      statusByte[ST_WEL] = wel_q;
      statusByte[ST_WIP] = busy_q;
   end

   // The status copy on the link side only moves while sck runs, so a
   // change made while deselected appears after a few clocks of the next
   // frame, well before the first status bit leaves.
   sync_3ff #(.WIDTH(8), .INIT(8'h00)) u_status_sync (
      .clk(sck),
      .rst_n(rst_n),
      .d(statusByte),
      .q(statusSck)
   );

   assign memWrEn = memWrEn_q;
   assign memWrAddr = memWrAddr_q;
   assign memWrData = memWrData_q;
   assign statusLock = lock_q;
   assign protectLevel = level_q;
   assign writeEnableLatch = wel_q;
   assign writeInProgress = busy_q;
   assign hardwareLockMode = hwLock_q;
   assign softwareLockMode = swLock_q;
endmodule : eeprom_protect_hold
`default_nettype wire

/* bench/spi_host_model.sv */
// Serial host model that frames commands and captures status bytes.
`default_nettype none
module spi_host_model (
   // Link pins toward the device
   output logic sck,
   output logic csN,
   output logic si,
   output logic holdN,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rdData;
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si = 1'b1;
      holdN = 1'b1;
      rdData = 8'h00;
   end
   // Sends n bits of d, MSB first. After bit hp a pause is taken with one
   // extra clock inside it; endHeld deselects while still paused.
   task automatic xfer(input logic [31:0] d, input int n, input int hp,
                       input bit endHeld);
      csN = 1'b0;
      #20;
      for (int i = 0; i < n; i++) begin
         si = d[31-i];
         #15 sck = 1'b1;
         if (i >= 8 && i < 16) rdData = {rdData[6:0], so};
         #5;
         if (i == hp) holdN = 1'b0;
         #10 sck = 1'b0;
         if (i == hp) begin
            si = ~si;
            #15 sck = 1'b1;
            #15 sck = 1'b0;
            if (!endHeld) #10 holdN = 1'b1;
         end
      end
      // Select stays low across a pause unless the caller asks otherwise.
      #20 csN = 1'b1;
      holdN = 1'b1;
      si = ~si;
      #200;
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* bench/eeprom_protect_hold_checker.sv */
// Concurrent checks on the ports of the protect and hold front end.
`default_nettype none
module eeprom_protect_hold_checker
   import eeprom_pkg::*;
#(
   parameter int BUSY = 4
) (
   // Clock, reset and link pins
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic wpN,
   input wire logic holdN,
   input wire logic so,
   input wire logic soOe,
   // Array write port and status
   input wire logic memWrEn,
   input wire logic [eeprom_pkg::ADDR_W-1:0] memWrAddr,
   input wire logic [eeprom_pkg::DATA_W-1:0] memWrData,
   input wire logic statusLock,
   input wire logic [1:0] protectLevel,
   input wire logic writeEnableLatch,
   input wire logic writeInProgress,
   input wire logic hardwareLockMode,
   input wire logic softwareLockMode
);
   logic [15:0] busyCnt_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busyCnt_q <= 16'h0000;
      end else begin
         busyCnt_q <= writeInProgress ? busyCnt_q + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_wr_deselected: assert property (memWrEn |-> csN)
      else $error("array write while selected");
   a_wr_latch_busy: assert property (memWrEn |-> writeEnableLatch &&
      writeInProgress) else $error("array write without latch");
   a_wr_range_ok: assert property (memWrEn |-> protectLevel == LVL_NONE ||
      (protectLevel == LVL_QUARTER && memWrAddr < QUARTER_BASE) ||
      (protectLevel == LVL_HALF && memWrAddr < HALF_BASE))
      else $error("write into protected range");
   a_busy_length: assert property ($fell(writeInProgress) |->
      busyCnt_q == 16'(BUSY)) else $error("busy length wrong");
   a_latch_end: assert property ($fell(writeInProgress) |->
      !writeEnableLatch) else $error("latch kept after write");
   a_status_frozen: assert property (($changed(statusLock) ||
      $changed(protectLevel)) |-> $fell(writeInProgress))
      else $error("status changed outside write end");
   a_lock_inverse: assert property (softwareLockMode != hardwareLockMode)
      else $error("lock modes agree");
   a_hw_needs_lock: assert property (hardwareLockMode |-> $past(statusLock))
      else $error("hardware lock without lock bit");
   a_wp_release: assert property (wpN [*8] |=> !hardwareLockMode)
      else $error("hardware lock with pin high");
   a_hold_floats: assert property (!holdN && !sck |-> !soOe)
      else $error("output driven in pause");
   a_out_selected: assert property (soOe |-> !csN)
      else $error("output driven while deselected");
   a_wel_deselect: assert property ($rose(writeEnableLatch) |-> csN)
      else $error("latch set while selected");
   c_wr: cover property (memWrEn);
   c_hw: cover property ($rose(hardwareLockMode));
   c_hold: cover property (!holdN && !csN && !sck);
endmodule : eeprom_protect_hold_checker
bind eeprom_protect_hold eeprom_protect_hold_checker #(
   .BUSY(WRITE_BUSY_CYCLES)
) i_eeprom_protect_hold_checker (
   .mclk(mclk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .wpN(wpN),
   .holdN(holdN), .so(so), .soOe(soOe), .memWrEn(memWrEn),
   .memWrAddr(memWrAddr), .memWrData(memWrData), .statusLock(statusLock),
   .protectLevel(protectLevel), .writeEnableLatch(writeEnableLatch),
   .writeInProgress(writeInProgress), .hardwareLockMode(hardwareLockMode),
   .softwareLockMode(softwareLockMode)
);
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the protect and hold front end.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import eeprom_pkg::*;
   localparam logic [7:0] WEN = 8'h11;
   localparam logic [7:0] WDIS = 8'h12;
   localparam logic [7:0] RDS = 8'h13;
   localparam logic [7:0] WRS = 8'h14;
   localparam logic [7:0] WRM = 8'h15;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic wpN = 1'b1;
   wire logic sck, csN, si, holdN, so, soOe, memWrEn, statusLock;
   wire logic [ADDR_W-1:0] memWrAddr;
   wire logic [DATA_W-1:0] memWrData;
   wire logic [1:0] protectLevel;
   wire logic writeEnableLatch, writeInProgress, hwLock, swLock;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'h9A2C;
   logic [21:0] expQ[$];
   logic [1:0] lb;
   logic [13:0] base;
   always #10 mclk = ~mclk;
   spi_host_model i_spi_host_model (
      .sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so)
   );
   eeprom_protect_hold #(
      .OP_WRITE_ENABLE(WEN), .OP_WRITE_DISABLE(WDIS),
      .OP_STATUS_READ(RDS), .OP_STATUS_WRITE(WRS), .OP_MEM_WRITE(WRM),
      .WRITE_BUSY_CYCLES(4)
   ) i_eeprom_protect_hold (
      .mclk(mclk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .wpN(wpN),
      .holdN(holdN), .so(so), .soOe(soOe), .memWrEn(memWrEn),
      .memWrAddr(memWrAddr), .memWrData(memWrData), .statusLock(statusLock),
      .protectLevel(protectLevel), .writeEnableLatch(writeEnableLatch),
      .writeInProgress(writeInProgress), .hardwareLockMode(hwLock),
      .softwareLockMode(swLock)
   );
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic results();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   task automatic cmpVal(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmpVal
   task automatic cmpWr();
      logic [21:0] e;
      e = 'x;
      num_checks++;
      if (expQ.size() > 0) e = expQ.pop_front();
      if ({memWrAddr, memWrData} !== e) begin
         num_errors++;
         $display("unexpected at %0t: write %h", $time, memWrAddr);
      end
   endtask : cmpWr
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         results();
      end
      if (memWrEn === 1'b1) cmpWr();
   end
   task automatic idle();
      repeat (4) @(posedge mclk);
      for (int k = 0; k < 60 && writeInProgress !== 1'b0; k++) begin
         @(posedge mclk);
      end
      #2;
   endtask : idle
   task automatic send(input logic [31:0] d, input int n);
      i_spi_host_model.xfer(d, n, -1, 1'b0);
      idle();
   endtask : send
   task automatic en();
      send({WEN, 24'h0}, 8);
   endtask : en
   task automatic memWr(input logic [13:0] a, input bit ok);
      rnd = xs(rnd);
      if (ok) expQ.push_back({a, rnd[7:0]});
      // Random top address bits must be dropped by the decode.
      send({WRM, rnd[15:14], a, rnd[7:0]}, 32);
   endtask : memWr
   task automatic rdSt(input logic [7:0] exp);
      send({RDS, 24'h0}, 16);
      cmpVal(i_spi_host_model.rdData, exp);
   endtask : rdSt
   task automatic setWp(input logic v);
      @(posedge mclk);
      #2 wpN = v;
      repeat (10) @(posedge mclk);
   endtask : setWp
   initial begin
      repeat (10) @(posedge mclk);
      #2 rst_n = 1'b1;
      repeat (12) @(posedge mclk);
      rdSt(8'h00);
      cmpVal({hwLock, swLock}, 8'h01);
      $display("test reset done");
      memWr(14'h0123, 1'b0);
      en();
      rdSt(8'h02);
      memWr(rnd[13:0], 1'b1);
      rdSt(8'h00);
      $display("test latch done");
      for (int l = 1; l < 4; l++) begin
         lb = l[1:0];
         base = l == 1 ? QUARTER_BASE : l == 2 ? HALF_BASE : ALL_BASE;
         en();
         send({WRS, 1'b0, 3'h7, lb, 2'h3, 16'h0}, 16);
         rdSt({4'h0, lb, 2'h0});
         for (int j = 0; j < 2; j++) begin
            en();
            memWr(base - 14'h1 + 14'(j), l != 3 && j == 0);
         end
      end
      en();
      send({WRS, 8'hFF, 16'h0}, 16);
      rdSt(8'h8C);
      $display("test levels done");
      setWp(1'b0);
      cmpVal({hwLock, swLock}, 8'h02);
      en();
      send({WRS, 8'h00, 16'h0}, 16);
      rdSt(8'h8E);
      setWp(1'b1);
      cmpVal({hwLock, swLock}, 8'h01);
      memWr(14'h0010, 1'b0);
      send({WRS, 8'h00, 16'h0}, 16);
      rdSt(8'h00);
      setWp(1'b0);
      en();
      send({WRS, 8'h80, 16'h0}, 16);
      rdSt(8'h80);
      cmpVal({hwLock, swLock}, 8'h02);
      setWp(1'b1);
      $display("test lock done");
      // A clock inside the pause would make nine clocks and void the frame.
      i_spi_host_model.xfer({WEN, 24'h0}, 8, 3, 1'b0);
      idle();
      cmpVal({7'h0, writeEnableLatch}, 8'h01);
      send({WDIS, 24'h0}, 8);
      i_spi_host_model.xfer({WEN, 24'h0}, 8, 7, 1'b1);
      idle();
      cmpVal({7'h0, writeEnableLatch}, 8'h00);
      $display("test hold done");
      en();
      @(posedge mclk);
      #2 rst_n = 1'b0;
      repeat (3) @(posedge mclk);
      #2 rst_n = 1'b1;
      repeat (12) @(posedge mclk);
      rdSt(8'h00);
      memWr(14'h0040, 1'b0);
      for (int k = 0; k < 3; k++) begin
         en();
         rnd = xs(rnd);
         memWr(rnd[13:0], 1'b1);
      end
      idle();
      cmpVal(8'(expQ.size()), 8'h00);
      $display("test supply done");
      results();
   end
endmodule : testbench
`default_nettype wire
